/* rtl/eeprom_master.sv */
// Two-wire bus controller with Avalon-MM command and status registers
`timescale 1ns/1ns
`default_nettype none
module eeprom_master #(
	parameter int QTR_CYC = eeprom_pkg::SCL_QTR_CYC
) (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	// Avalon-MM slave
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output var  logic [31:0] o_avs_readdata,
	output var  logic        o_avs_waitrequest,
	// Link
	eeprom_if.host           link
);
	localparam int QW = $clog2(QTR_CYC + 1);

	typedef enum {H_IDLE, H_START, H_BIT, H_STOP} hstate_t;

	hstate_t    hst_ff;
	logic [1:0] ph_ff;
	logic [QW-1:0] q_ff;
	logic [3:0] idx_ff;
	logic [7:0] sh_ff;
	logic [7:0] rdata_ff;
	logic       rd_cmd_ff;
	logic       acksend_ff;
	logic       ackseen_ff;
	logic       busy_ff;
	logic       scl_ff;
	logic       oe_n_ff;
	logic       wait_ff;
	logic [31:0] rdd_ff;
	logic [10:0] ctrl_ff;
	logic       s1_ff;
	logic       s2_ff;

	// ****************************************************************
	// Register access
	// ****************************************************************
	logic launch;
	logic tick;
	assign launch = i_avs_write && !wait_ff
		&& i_avs_address == eeprom_pkg::REG_CTRL && !busy_ff;
	assign tick   = hst_ff != H_IDLE && q_ff == '0;

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			wait_ff <= 1'b1;
			rdd_ff  <= 32'h0000_0000;
			ctrl_ff <= 11'h000;
		end
		else
		begin
			wait_ff <= ~((i_avs_read | i_avs_write) & wait_ff);
			if (launch)
				ctrl_ff <= i_avs_writedata[10:0];
			if (i_avs_read && wait_ff)
				unique case (i_avs_address)
					eeprom_pkg::REG_CTRL:
						rdd_ff <= {21'h0, ctrl_ff};
					eeprom_pkg::REG_STATUS:
					begin
						rdd_ff <= 32'h0;
						rdd_ff[eeprom_pkg::STAT_BUSY_BIT] <= busy_ff;
						rdd_ff[eeprom_pkg::STAT_ACK_BIT]  <= ackseen_ff;
						rdd_ff[eeprom_pkg::STAT_DATA_LSB +: 8] <= rdata_ff;
					end
					default:
						rdd_ff <= 32'h0;
				endcase
		end
	end

	// ****************************************************************
	// Data line synchroniser
	// ****************************************************************
	always_ff @(posedge i_mclk)
	begin
		s1_ff <= link.sda;
		s2_ff <= s1_ff;
	end

	// Clock level and data release for a given step
	function automatic logic [1:0] drive(input hstate_t st,
		input logic [1:0] ph, input logic bitv);
		drive = {1'b0, 1'b1};
		unique case (st)
			H_START:
				drive = {ph == 2'd1 || ph == 2'd2, ph < 2'd2};
			H_BIT:
				drive = {ph == 2'd1 || ph == 2'd2, bitv}; // RULE_01
			H_STOP:
				drive = {ph != 2'd0, ph >= 2'd2};
			H_IDLE:
				drive = {1'b1, 1'b1};
		endcase
	endfunction : drive

	logic bitv;
	logic nbitv;
	assign bitv  = (idx_ff == 4'h8) ? (rd_cmd_ff ? ~acksend_ff : 1'b1)
		: (rd_cmd_ff ? 1'b1 : sh_ff[7]); // RULE_08 RULE_22
	assign nbitv = (idx_ff == 4'h7) ? (rd_cmd_ff ? ~acksend_ff : 1'b1)
		: (rd_cmd_ff ? 1'b1 : sh_ff[7]);

	// ****************************************************************
	// Bit engine
	// ****************************************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			hst_ff     <= H_IDLE;
			ph_ff      <= 2'd0;
			q_ff       <= '0;
			idx_ff     <= 4'h0;
			sh_ff      <= 8'h00;
			rdata_ff   <= 8'h00;
			rd_cmd_ff  <= 1'b0;
			acksend_ff <= 1'b0;
			ackseen_ff <= 1'b0;
			busy_ff    <= 1'b0;
			scl_ff     <= 1'b1;
			oe_n_ff    <= 1'b1;
		end
		else if (launch)
		begin
			unique case (eeprom_pkg::cmd_t'(
				i_avs_writedata[eeprom_pkg::CTRL_CMD_LSB +: 2]))
				eeprom_pkg::CMD_START: hst_ff <= H_START; // RULE_04
				eeprom_pkg::CMD_STOP:  hst_ff <= H_STOP;
				default:               hst_ff <= H_BIT; // RULE_10 RULE_13
			endcase
			rd_cmd_ff  <= i_avs_writedata[eeprom_pkg::CTRL_CMD_LSB +: 2]
				== 2'(eeprom_pkg::CMD_READ);
			acksend_ff <= i_avs_writedata[eeprom_pkg::CTRL_ACK_BIT];
			sh_ff      <= i_avs_writedata[eeprom_pkg::CTRL_DATA_LSB +: 8];
			busy_ff    <= 1'b1;
			ph_ff      <= 2'd0;
			idx_ff     <= 4'h0;
			q_ff       <= QW'(QTR_CYC - 1);
			scl_ff     <= 1'b0;
		end
		else if (hst_ff != H_IDLE)
		begin
			if (!tick)
				q_ff <= QW'(q_ff - 1'b1);
			else
			begin
				q_ff <= QW'(QTR_CYC - 1);
				if (hst_ff == H_BIT && ph_ff == 2'd2)
				begin
					if (idx_ff == 4'h8)
						ackseen_ff <= ~s2_ff; // RULE_16
					else
						sh_ff <= {sh_ff[6:0], s2_ff}; // RULE_01
				end
				if (ph_ff == 2'd3)
				begin
					if (hst_ff == H_BIT && idx_ff != 4'h8)
					begin
						idx_ff  <= idx_ff + 4'h1;
						ph_ff   <= 2'd0;
						oe_n_ff <= nbitv; // RULE_01
					end
					else
					begin
						hst_ff   <= H_IDLE;
						busy_ff  <= 1'b0;
						rdata_ff <= sh_ff;
					end
				end
				else
				begin
					ph_ff <= ph_ff + 2'd1;
					{scl_ff, oe_n_ff} <= drive(hst_ff, ph_ff + 2'd1, bitv);
				end
			end
			if (q_ff == QW'(QTR_CYC - 1) && ph_ff == 2'd0 && !tick)
				{scl_ff, oe_n_ff} <= drive(hst_ff, 2'd0, bitv);
		end
	end

	assign link.scl           = scl_ff;
	assign link.host_sda_o    = 1'b0;
	assign link.host_sda_oe_n = oe_n_ff;
	assign o_avs_readdata     = rdd_ff;
	assign o_avs_waitrequest  = wait_ff;

endmodule : eeprom_master
`default_nettype wire

/* rtl/eeprom_target.sv */
// Two-wire serial memory target with page write and self-timed program
// Function
// RULE_01 - Sample on clock rise, change on fall
// RULE_02 - Data line only pulled low or released
// RULE_03 - Page size and address width follow density
// RULE_04 - Device word follows start, fixed type nibble
// RULE_05 - Small parts match all three select pins
// RULE_06 - Larger parts swap select bits for page bits
// RULE_07 - Page bits become top word address bits
// RULE_08 - Last device word bit: one reads
// RULE_09 - Acknowledge match, else back to standby
// RULE_10 - Byte write: address, data, both acknowledged
// RULE_11 - Stop starts program cycle, bus ignored
// RULE_12 - Program cycle ends within five milliseconds
// RULE_13 - Page write takes bytes until stop
// RULE_14 - Low address bits wrap inside page
// RULE_15 - Partial page writes only received bytes
// RULE_16 - Polling acknowledged only after programming ends
// RULE_17 - Write-protect high blocks all programming
// RULE_18 - Reads: current, random and sequential kinds
// RULE_19 - Address counter holds last access plus one
// RULE_20 - Current read sends byte at counter
// RULE_21 - Random read: dummy write then restart
// RULE_22 - Acknowledged reads continue, wrapping whole array
// RULE_23 - Stop without data byte starts no program
`timescale 1ns/1ns
`default_nettype none
module eeprom_target #(
	parameter int ADDR_BITS = eeprom_pkg::DEF_ADDR_BITS,
	parameter int PROG_CYC  = eeprom_pkg::WRITE_CYCLE_CYC
) (
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst,
	// Link
	eeprom_if.dev     link,
	// Straps and status
	input  wire logic i_select_pin_low,
	input  wire logic i_select_pin_mid,
	input  wire logic i_select_pin_high,
	input  wire logic i_wp,
	output var  logic o_busy
);
	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int PG_BITS  = (ADDR_BITS <= 8) ? 3 : 4;
	localparam int PAGE_SZ  = 1 << PG_BITS;
	localparam int DEPTH    = 1 << ADDR_BITS;
	localparam int SEL_BITS = (ADDR_BITS > 8) ? ADDR_BITS - 8 : 0;
	localparam int PCW      = $clog2(PROG_CYC + 1);
	localparam logic [2:0] CMP_MASK = 3'(3'h7 << SEL_BITS); // RULE_06

	typedef enum {ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_RD, ST_PROG}
		state_t;

	state_t               state_ff;
	logic [3:0]           cnt_ff;
	logic [7:0]           sh_ff;
	logic [7:0]           tx_ff;
	logic                 ack_ff;
	logic                 rw_ff;
	logic                 mack_ff;
	logic [2:0]           page_ff;
	logic                 sda_oe_n_ff;
	logic                 busy_ff;
	logic [ADDR_BITS-1:0] addr_ff;
	logic [PCW-1:0]       prog_cnt_ff;
	logic [5:0]           s1_ff;
	logic [5:0]           s2_ff;
	logic [5:0]           s3_ff;
	logic [7:0]           mem [DEPTH];
	logic [7:0]           pbuf [PAGE_SZ];
	logic [PAGE_SZ-1:0]   pmask_ff;

	function automatic logic dev_match(input logic [7:0] b,
		input logic [2:0] pins);
		dev_match = (b[7:4] == eeprom_pkg::DEV_TYPE_CODE)
			&& (((b[3:1] ^ pins) & CMP_MASK) == 3'h0); // RULE_04 RULE_05
	endfunction : dev_match

	// ****************************************************************
	// Input synchronisers and condition detect
	// ****************************************************************
	always_ff @(posedge i_mclk)
	begin
		s1_ff <= {link.scl, link.sda, i_select_pin_high,
			i_select_pin_mid, i_select_pin_low, i_wp};
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
	end

	logic scl;
	logic sda;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic wp;
	logic [2:0] pins;
	assign scl   = s2_ff[5];
	assign sda   = s2_ff[4];
	assign pins  = s2_ff[3:1];
	assign wp    = s2_ff[0];
	assign rise  = scl & ~s3_ff[5]; // RULE_01
	assign fall  = ~scl & s3_ff[5]; // RULE_01
	assign start = scl & s3_ff[5] & s3_ff[4] & ~sda;
	assign stop  = scl & s3_ff[5] & ~s3_ff[4] & sda;

	logic rx_state;
	logic byte_end;
	logic ack_end;
	logic store_en;
	logic commit_en;
	logic load_en;
	logic prog_done;
	logic [10:0] wide_addr;
	logic [7:0]  mem_q;
	assign rx_state  = (state_ff == ST_DEV) || (state_ff == ST_WADDR)
		|| (state_ff == ST_WDATA);
	assign byte_end  = rx_state && fall && cnt_ff == 4'h8 && !ack_ff;
	assign ack_end   = rx_state && fall && cnt_ff == 4'h8 && ack_ff;
	assign store_en  = byte_end && state_ff == ST_WDATA;
	assign commit_en = stop && state_ff == ST_WDATA
		&& (|pmask_ff) && !wp; // RULE_11 RULE_17 RULE_23
	assign load_en   = (ack_end && state_ff == ST_DEV && rw_ff)
		|| (state_ff == ST_RD && fall && cnt_ff == 4'h9 && mack_ff);
	assign prog_done = state_ff == ST_PROG && prog_cnt_ff == '0;
	assign wide_addr = {page_ff, sh_ff}; // RULE_07
	assign mem_q     = mem[addr_ff];

	// ****************************************************************
	// Bit and byte sequencing
	// ****************************************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			state_ff    <= ST_IDLE;
			cnt_ff      <= 4'h0;
			sh_ff       <= 8'h00;
			tx_ff       <= 8'h00;
			ack_ff      <= 1'b0;
			rw_ff       <= 1'b0;
			mack_ff     <= 1'b0;
			page_ff     <= 3'h0;
			sda_oe_n_ff <= 1'b1;
		end
		else if (state_ff == ST_PROG)
		begin
			sda_oe_n_ff <= 1'b1; // RULE_11 RULE_16
			if (prog_done)
				state_ff <= ST_IDLE;
		end
		else if (start)
		begin
			state_ff    <= ST_DEV; // RULE_04
			cnt_ff      <= 4'h0;
			ack_ff      <= 1'b0;
			sda_oe_n_ff <= 1'b1;
		end
		else if (stop)
		begin
			state_ff    <= commit_en ? ST_PROG : ST_IDLE; // RULE_11
			sda_oe_n_ff <= 1'b1;
		end
		else if (state_ff == ST_RD)
		begin
			if (rise)
			begin
				cnt_ff <= cnt_ff + 4'h1;
				if (cnt_ff == 4'h8)
					mack_ff <= ~sda; // RULE_22
			end
			else if (fall)
			begin
				if (cnt_ff == 4'h9)
				begin
					if (mack_ff)
					begin
						tx_ff       <= mem_q; // RULE_22
						sda_oe_n_ff <= mem_q[7];
						cnt_ff      <= 4'h0;
					end
					else
					begin
						state_ff    <= ST_IDLE; // RULE_20
						sda_oe_n_ff <= 1'b1;
					end
				end
				else if (cnt_ff == 4'h8)
					sda_oe_n_ff <= 1'b1;
				else
				begin
					tx_ff       <= {tx_ff[6:0], 1'b0};
					sda_oe_n_ff <= tx_ff[6]; // RULE_01 RULE_02
				end
			end
		end
		else if (rx_state)
		begin
			if (rise && cnt_ff < 4'h8)
			begin
				sh_ff  <= {sh_ff[6:0], sda}; // RULE_01
				cnt_ff <= cnt_ff + 4'h1;
			end
			else if (byte_end)
			begin
				if (state_ff == ST_DEV && !dev_match(sh_ff, pins))
					state_ff <= ST_IDLE; // RULE_09
				else
				begin
					ack_ff      <= 1'b1;
					sda_oe_n_ff <= 1'b0; // RULE_09 RULE_10 RULE_13
					if (state_ff == ST_DEV)
					begin
						rw_ff   <= sh_ff[0]; // RULE_08
						page_ff <= sh_ff[3:1] & ~CMP_MASK; // RULE_06
					end
				end
			end
			else if (ack_end)
			begin
				ack_ff <= 1'b0;
				cnt_ff <= 4'h0;
				if (state_ff == ST_DEV && rw_ff)
				begin
					state_ff    <= ST_RD; // RULE_18 RULE_20
					tx_ff       <= mem_q;
					sda_oe_n_ff <= mem_q[7];
				end
				else
				begin
					sda_oe_n_ff <= 1'b1;
					state_ff    <= (state_ff == ST_DEV) ? ST_WADDR : ST_WDATA;
				end
			end
		end
	end

	// ****************************************************************
	// Word address counter
	// ****************************************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			addr_ff <= '0;
		else if (byte_end && state_ff == ST_WADDR)
			addr_ff <= wide_addr[ADDR_BITS-1:0]; // RULE_03 RULE_07
		else if (store_en)
			addr_ff[PG_BITS-1:0] <=
				PG_BITS'(addr_ff[PG_BITS-1:0] + 1'b1); // RULE_14
		else if (load_en)
			addr_ff <= ADDR_BITS'(addr_ff + 1'b1); // RULE_19 RULE_22
	end

	// ****************************************************************
	// Page buffer and array
	// ****************************************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_rst || start || commit_en)
			pmask_ff <= '0;
		else if (store_en)
			pmask_ff[addr_ff[PG_BITS-1:0]] <= 1'b1; // RULE_15
	end

	always_ff @(posedge i_mclk)
	begin
		if (store_en)
			pbuf[addr_ff[PG_BITS-1:0]] <= sh_ff; // RULE_13 RULE_14
		if (commit_en)
		begin
			for (int i = 0; i < PAGE_SZ; i++)
				if (pmask_ff[i])
					mem[{addr_ff[ADDR_BITS-1:PG_BITS],
						PG_BITS'(i)}] <= pbuf[i]; // RULE_15
		end
	end

	// ****************************************************************
	// Program timer
	// ****************************************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			prog_cnt_ff <= '0;
			busy_ff     <= 1'b0;
		end
		else if (commit_en)
		begin
			prog_cnt_ff <= PCW'(PROG_CYC - 1); // RULE_12
			busy_ff     <= 1'b1;
		end
		else if (prog_done)
			busy_ff <= 1'b0;
		else if (state_ff == ST_PROG)
			prog_cnt_ff <= PCW'(prog_cnt_ff - 1'b1);
	end

	assign link.dev_sda_o    = 1'b0; // RULE_02
	assign link.dev_sda_oe_n = sda_oe_n_ff;
	assign o_busy            = busy_ff;

endmodule : eeprom_target
`default_nettype wire

/* shared/eeprom_if.sv */
// Two-wire link between memory target and bus controller
`timescale 1ns/1ns
`default_nettype none
interface eeprom_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic sda;

	// Wired-AND of both open-drain drivers with pull-up
	assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o)
		& (dev_sda_oe_n ? 1'b1 : dev_sda_o);

	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe_n
	);

	modport host (
		output scl,
		output host_sda_o,
		output host_sda_oe_n,
		input  sda
	);
endinterface : eeprom_if
`default_nettype wire

/* shared/eeprom_pkg.sv */
// Shared constants for the two-wire serial memory target and controller
package eeprom_pkg;

	// ****************************************************************
	// Link framing
	// ****************************************************************
	localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
	localparam int         DEF_ADDR_BITS = 11;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS   = 20;
	localparam int WRITE_CYCLE_US  = 5000;
	localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_US * 1000 / CLK_PERIOD_NS;
	localparam int SCL_KHZ         = 400;
	localparam int SCL_QTR_CYC     =
		(1000000 / SCL_KHZ) / (4 * CLK_PERIOD_NS);

	// ****************************************************************
	// Controller registers
	// ****************************************************************
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_STATUS    = 4'h4;
	localparam int         CTRL_DATA_LSB = 0;
	localparam int         CTRL_CMD_LSB  = 8;
	localparam int         CTRL_ACK_BIT  = 10;
	localparam int         STAT_BUSY_BIT = 0;
	localparam int         STAT_ACK_BIT  = 1;
	localparam int         STAT_DATA_LSB = 8;

	typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP}
		cmd_t;

endpackage : eeprom_pkg

/* tb/eeprom_link_properties.sv */
// Concurrent checks on the two-wire link between target and controller
`timescale 1ns/1ns
`default_nettype none
module eeprom_link_properties #(
	parameter int PROG_CYC = 200
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Link signals
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	// Target straps and status
	input wire logic i_wp,
	input wire logic o_busy
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	logic [31:0] busy_cnt_ff;

	// ************************************************
	// Program cycle length counter
	// ************************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_rst || !o_busy)
			busy_cnt_ff <= 32'h0;
		else
			busy_cnt_ff <= busy_cnt_ff + 32'h1;
	end

	// ************************************************
	// Assertions
	// ************************************************
	dev_pull_low_a: assert property (!dev_sda_oe_n |-> !dev_sda_o)
		else $error("target drives sda high");
	host_pull_low_a: assert property (!host_sda_oe_n |-> !host_sda_o)
		else $error("controller drives sda high");
	dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("target changed sda while scl high");
	ack_hold_a: assert property (
		$rose(scl) && !dev_sda_oe_n |=> (!dev_sda_oe_n) [*8])
		else $error("target released sda during scl high");
	busy_quiet_a: assert property (o_busy |-> dev_sda_oe_n)
		else $error("target answered during program cycle");
	busy_at_stop_a: assert property ($rose(o_busy) |-> scl && sda)
		else $error("program cycle began outside stop");
	busy_len_a: assert property (
		busy_cnt_ff <= 32'(PROG_CYC) + 32'h2)
		else $error("program cycle too long");
	busy_min_a: assert property (
		$fell(o_busy) |-> busy_cnt_ff + 32'h4 >= 32'(PROG_CYC))
		else $error("program cycle too short");
	wp_no_prog_a: assert property (
		$rose(o_busy) |-> !i_wp && !$past(i_wp, 4))
		else $error("programming while write protected");
	stop_idle_a: assert property (
		scl && $rose(sda) |=> scl [*8])
		else $error("scl dropped right after stop");

	busy_c: cover property ($rose(o_busy));
	ack_c: cover property ($rose(scl) && !dev_sda_oe_n);
	stop_c: cover property (scl && $rose(sda));
endmodule : eeprom_link_properties
`default_nettype wire

/* tb/test_two_wire_serial_eeprom_slave.sv */
// Self-checking bench: controller and memory target joined on one link
`timescale 1ns/1ns
`default_nettype none
module test_two_wire_serial_eeprom_slave;
	localparam int PROG = 2000;
	logic        i_mclk, i_rst, wp, pin_low, busy, wreq;
	logic        pin_mid, pin_high;
	logic [3:0]  av_addr;
	logic        av_rd, av_wr;
	logic [31:0] av_wd, av_rdata, st;
	logic [7:0]  mem [512];
	logic [8:0]  ptr;
	int          error_cnt, check_count;

	eeprom_if eeprom_if_i ();
	eeprom_master #(.QTR_CYC(8)) eeprom_master_i (.i_mclk(i_mclk),
		.i_rst(i_rst), .i_avs_address(av_addr), .i_avs_read(av_rd),
		.i_avs_write(av_wr), .i_avs_writedata(av_wd),
		.o_avs_readdata(av_rdata), .o_avs_waitrequest(wreq),
		.link(eeprom_if_i));
	eeprom_target #(.ADDR_BITS(9), .PROG_CYC(PROG)) eeprom_target_i (
		.i_mclk(i_mclk), .i_rst(i_rst), .link(eeprom_if_i),
		.i_select_pin_low(pin_low), .i_select_pin_mid(pin_mid),
		.i_select_pin_high(pin_high), .i_wp(wp), .o_busy(busy));
	eeprom_link_properties #(.PROG_CYC(PROG)) eeprom_link_properties_i (
		.i_mclk(i_mclk), .i_rst(i_rst), .scl(eeprom_if_i.scl),
		.sda(eeprom_if_i.sda), .host_sda_o(eeprom_if_i.host_sda_o),
		.host_sda_oe_n(eeprom_if_i.host_sda_oe_n),
		.dev_sda_o(eeprom_if_i.dev_sda_o),
		.dev_sda_oe_n(eeprom_if_i.dev_sda_oe_n), .i_wp(wp), .o_busy(busy));

	// ************************************************
	// Bus cycles and comparison
	// ************************************************
	task automatic chk(input string what, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	task automatic av(input logic [3:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_mclk);
		av_addr <= a;
		av_wr <= w;
		av_rd <= !w;
		av_wd <= d;
		do
			@(posedge i_mclk);
		while (wreq);
		q = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask : av

	task automatic cmd(input eeprom_pkg::cmd_t c, input logic [7:0] b,
		input logic ack);
		logic [31:0] d;
		d = 32'(b) | (32'(c) << eeprom_pkg::CTRL_CMD_LSB)
			| (32'(ack) << eeprom_pkg::CTRL_ACK_BIT);
		av(eeprom_pkg::REG_CTRL, 1'b1, d, st);
		st = 32'h1;
		while (st[eeprom_pkg::STAT_BUSY_BIT])
			av(eeprom_pkg::REG_STATUS, 1'b0, 32'h0, st);
	endtask : cmd

	task automatic wb(input logic [7:0] b, input logic ack);
		cmd(eeprom_pkg::CMD_WRITE, b, 1'b0);
		chk("ack", 32'(ack), 32'(st[eeprom_pkg::STAT_ACK_BIT]));
	endtask : wb

	// Device word for the strapped select pins
	function automatic logic [7:0] dw(input logic pg, input logic rd);
		return {eeprom_pkg::DEV_TYPE_CODE, pin_high, pin_mid, pg, rd};
	endfunction : dw

	// ************************************************
	// Link sequences with reference model
	// ************************************************
	task automatic wseq(input logic pg, input logic [7:0] a, input int n);
		logic [7:0] d;
		cmd(eeprom_pkg::CMD_START, 8'h00, 1'b0);
		wb(dw(pg, 1'b0), 1'b1);
		wb(a, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			d = 8'($urandom);
			wb(d, 1'b1);
			if (!wp)
				mem[{pg, a[7:4], a[3:0] + 4'(i)}] = d;
		end
		cmd(eeprom_pkg::CMD_STOP, 8'h00, 1'b0);
		repeat (4) @(posedge i_mclk);
		chk("busy", 32'(n > 0 && !wp), 32'(busy));
		ptr = {pg, a};
	endtask : wseq

	task automatic settle();
		cmd(eeprom_pkg::CMD_START, 8'h00, 1'b0);
		wb(dw(1'b0, 1'b0), 1'b0);
		cmd(eeprom_pkg::CMD_STOP, 8'h00, 1'b0);
		repeat (3000) if (busy) @(posedge i_mclk);
		chk("busy", 32'h0, 32'(busy));
		cmd(eeprom_pkg::CMD_START, 8'h00, 1'b0);
		wb(dw(1'b0, 1'b0), 1'b1);
		cmd(eeprom_pkg::CMD_STOP, 8'h00, 1'b0);
	endtask : settle

	task automatic rseq(input int n);
		cmd(eeprom_pkg::CMD_START, 8'h00, 1'b0);
		wb(dw(ptr[8], 1'b1), 1'b1);
		for (int i = 0; i < n; i++)
		begin
			cmd(eeprom_pkg::CMD_READ, 8'h00, 1'(i < n - 1));
			chk("data", 32'(mem[ptr]), 32'(st[15:8]));
			ptr++;
		end
		cmd(eeprom_pkg::CMD_STOP, 8'h00, 1'b0);
	endtask : rseq

	initial
	begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	initial
	begin
		#1000000;
		error_cnt++;
		conclude();
	end

	initial
	begin
		i_rst = 1'b1;
		wp = 1'b0;
		av_addr = 4'h0;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_wd = 32'h0;
		error_cnt = 0;
		check_count = 0;
		void'($urandom(32'hbce5));
		pin_low = 1'($urandom);
		pin_mid = 1'($urandom);
		pin_high = 1'($urandom);
		repeat (6) @(posedge i_mclk);
		i_rst <= 1'b0;
		wseq(1'b1, 8'hfe, 18);
		settle();
		wseq(1'b0, 8'h00, 3);
		settle();
		wp <= 1'b1;
		wseq(1'b0, 8'h01, 1);
		wp <= 1'b0;
		cmd(eeprom_pkg::CMD_START, 8'h00, 1'b0);
		wb(dw(1'b0, 1'b0) ^ 8'h08, 1'b0);
		cmd(eeprom_pkg::CMD_STOP, 8'h00, 1'b0);
		wseq(1'b1, 8'hfe, 0);
		rseq(4);
		cmd(eeprom_pkg::CMD_START, 8'h00, 1'b0);
		wb(dw(1'b0, 1'b0), 1'b1);
		wb(8'h01, 1'b1);
		ptr = 9'h001;
		rseq(1);
		av(eeprom_pkg::REG_CTRL, 1'b0, 32'h0, st);
		chk("ctrl", 32'(eeprom_pkg::CMD_STOP)
			<< eeprom_pkg::CTRL_CMD_LSB, st);
		conclude();
	end
endmodule : test_two_wire_serial_eeprom_slave
`default_nettype wire
